// ### verilog/rtc_window_pkg.sv
// Constants shared by the clock unit's indirect access window
package rtc_window_pkg;

    // Host-visible register offsets
    localparam logic [7:0] SELECT_OFFSET     = 8'h0b;
    localparam logic [7:0] VALUE_OFFSET      = 8'h0c;

    // indirect_select fields
    localparam int         SEL_BUSY_BIT      = 7;
    localparam int         SEL_AUTO_BIT      = 6;
    localparam int         SEL_SHORT_BIT     = 4;
    localparam logic [7:0] SELECT_RESET      = 8'h00;
    localparam logic [7:0] VALUE_RESET       = 8'h00;

    // Internal register indices
    localparam logic [3:0] IDX_SNAP0         = 4'h0;
    localparam logic [3:0] IDX_CTRL          = 4'h4;
    localparam logic [3:0] IDX_OSC           = 4'h5;
    localparam logic [3:0] IDX_LOADCAP       = 4'h6;
    localparam logic [3:0] IDX_MATCH0        = 4'h8;
    localparam logic [1:0] SNAP_GROUP        = 2'h0;
    localparam logic [1:0] MATCH_GROUP       = 2'h2;

    // Control register fields
    localparam int         CTRL_RUN_BIT      = 0;
    localparam int         CTRL_CAPTURE_BIT  = 1;
    localparam int         CTRL_LOAD_BIT     = 2;
    localparam int         CTRL_MISSING_BIT  = 5;
    localparam int         CTRL_MISSDET_BIT  = 6;

    // Oscillator register fields
    localparam int         OSC_POWER_BIT     = 0;
    localparam int         OSC_VALID_BIT     = 4;
    localparam int         OSC_BIAS_BIT      = 5;
    localparam int         OSC_AMP_BIT       = 6;
    localparam int         OSC_TYPE_BIT      = 7;

    // Load capacitance register fields
    localparam int         LOADCAP_READY_BIT = 7;
    localparam logic [3:0] LOADCAP_RESET     = 4'h0;

    // Timebase rates
    localparam int         SYS_CLK_HZ        = 20_000_000;
    localparam int         CRYSTAL_HZ        = 32_768;
    localparam int         SELF_LOW_HZ       = 20_000;
    localparam int         SELF_HIGH_HZ      = 40_000;
    localparam logic [10:0] CRYSTAL_DIV      = 11'(SYS_CLK_HZ / CRYSTAL_HZ);
    localparam logic [10:0] SELF_LOW_DIV     = 11'(SYS_CLK_HZ / SELF_LOW_HZ);
    localparam logic [10:0] SELF_HIGH_DIV    = 11'(SYS_CLK_HZ / SELF_HIGH_HZ);
    localparam logic [10:0] TRIM_STEP        = 11'h008;

    // Startup blanking and missing-clock timeout
    localparam int         STARTUP_MS        = 2;
    localparam int         STARTUP_CYCLES    = SYS_CLK_HZ / 1000 * STARTUP_MS;
    localparam int         MISSING_US        = 100;
    localparam logic [11:0] MISSING_CYCLES   = 12'(SYS_CLK_HZ / 1_000_000 * MISSING_US);

    // Indirect read latency, long and short strobe
    localparam logic       FETCH_WAIT_LONG   = 1'b1;
    localparam logic       FETCH_WAIT_SHORT  = 1'b0;

    // Indirect read sequencer
    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b01,
        FETCH_RUN  = 2'b10
    } fetch_state_t;

endpackage : rtc_window_pkg

// ### verilog/rtc_window.sv
// Functional notes
// - Low four select bits pick the internal register the value register reaches.
// - Snapshot and match byte accesses advance the index by one afterwards.
// - Value register carries the byte written to or read from the selection.
// - Select bit 6 turns automatic fetch after value reads off or on.
// - Clock unit runs from its own oscillator timebase, not the system clock.
// - Oscillator offers crystal mode at 32.768 kHz and self-oscillating mode.
// - With CMOS clock valid flag is meaningless; check missing flag after 2 ms.
// - Self-oscillating: bias double 0 gives about 20 kHz, 1 about 40 kHz.
// - Self-oscillating mode runs at once with no startup wait.
// - Select holds busy, auto fetch, short strobe, index; top bits reset 0.
`timescale 1ns/1ps
`default_nettype none

module rtc_window
    import rtc_window_pkg::*;
#(
    parameter int STARTUP_LEN = STARTUP_CYCLES
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Host register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Clock unit status
    output logic            rtc_tick_o,
    output logic            osc_missing_o
);

    // Host-visible state
    fetch_state_t state_q;
    fetch_state_t state_d;
    logic         wait_q;
    logic [3:0]   index_q;
    logic [3:0]   index_d;
    logic         auto_q;
    logic         short_q;
    logic [7:0]   value_q;

    // Internal clock registers
    logic [7:0]   snap_q [4];
    logic [7:0]   match_q [4];
    logic [31:0]  timer_q;
    logic         run_q;
    logic         missdet_q;
    logic         missing_q;
    logic         osc_type_select_q;
    logic         amplitude_control_enable_q;
    logic         bias_double_select_q;
    logic         osc_power_enable_q;
    logic         osc_valid_flag_q;
    logic [3:0]   load_cap_config_q;
    logic [3:0]   cap_step_q;

    // Timebase
    logic [10:0]  div_q;
    logic [31:0]  startup_q;
    logic [11:0]  miss_cnt_q;

    // Snapshot and match bytes auto-advance the index
    function automatic logic is_block_index(input logic [3:0] idx);
        return (idx[3:2] == SNAP_GROUP) || (idx[3:2] == MATCH_GROUP);
    endfunction

    // Host access decode
    wire sel_wr = reg_wr_i && (reg_addr_i == SELECT_OFFSET);
    wire val_wr = reg_wr_i && (reg_addr_i == VALUE_OFFSET);
    wire val_rd = reg_rd_i && (reg_addr_i == VALUE_OFFSET);
    wire idle   = (state_q == FETCH_IDLE);

    wire start_by_busy = sel_wr && reg_wdata_i[SEL_BUSY_BIT];
    wire start_by_auto = val_rd && auto_q && idle;
    wire fetch_start   = idle && (start_by_busy || start_by_auto);
    wire fetch_done    = (state_q == FETCH_RUN) && !wait_q;

    wire idx_wr     = val_wr && idle;
    wire ctrl_wr    = idx_wr && (index_q == IDX_CTRL);
    wire osc_wr     = idx_wr && (index_q == IDX_OSC);
    wire loadcap_wr = idx_wr && (index_q == IDX_LOADCAP);

    wire block_step = (idx_wr || fetch_done) && is_block_index(index_q);

    // Capture snapshots the timer, load copies snapshot into it
    wire capture_cmd = ctrl_wr && reg_wdata_i[CTRL_CAPTURE_BIT];
    wire load_cmd    = ctrl_wr && reg_wdata_i[CTRL_LOAD_BIT];
    wire [31:0] snap_word = {snap_q[3], snap_q[2], snap_q[1], snap_q[0]};

    // bias double picks 20 or 40 kHz
    wire [10:0] self_base = bias_double_select_q ? SELF_HIGH_DIV : SELF_LOW_DIV;
    wire [10:0] trim      = 11'(cap_step_q) * TRIM_STEP;
    wire [10:0] div_limit = osc_type_select_q ? CRYSTAL_DIV : 11'(self_base + trim);

    // clock unit ticks from oscillator timebase
    wire tick = osc_power_enable_q && (div_q == 11'h000);

    // Missing clock: no tick for the timeout while detector is on
    wire miss_event = missdet_q && (miss_cnt_q == MISSING_CYCLES);

    // Load capacitance reaches its programmed value
    wire cap_ready = (cap_step_q == load_cap_config_q) && osc_valid_flag_q;

    wire [7:0] select_view = {(state_q == FETCH_RUN), auto_q, 1'b0, short_q, index_q};

    logic [7:0] internal_rd;
    always_comb begin
        internal_rd = 8'h00;
        unique case (index_q[3:2])
            SNAP_GROUP:  internal_rd = snap_q[index_q[1:0]];
            MATCH_GROUP: internal_rd = match_q[index_q[1:0]];
            default: begin
                if (index_q == IDX_CTRL) begin
                    internal_rd[CTRL_RUN_BIT]     = run_q;
                    internal_rd[CTRL_MISSING_BIT] = missing_q;
                    internal_rd[CTRL_MISSDET_BIT] = missdet_q;
                end else if (index_q == IDX_OSC) begin
                    internal_rd[OSC_POWER_BIT] = osc_power_enable_q;
                    internal_rd[OSC_VALID_BIT] = osc_valid_flag_q;
                    internal_rd[OSC_BIAS_BIT]  = bias_double_select_q;
                    internal_rd[OSC_AMP_BIT]   = amplitude_control_enable_q;
                    internal_rd[OSC_TYPE_BIT]  = osc_type_select_q;
                end else if (index_q == IDX_LOADCAP) begin
                    internal_rd[3:0]               = load_cap_config_q;
                    internal_rd[LOADCAP_READY_BIT] = cap_ready;
                end
            end
        endcase
    end

    // Host read data selection
    wire [7:0] rdata_d = (reg_addr_i == SELECT_OFFSET) ? select_view :
                         (reg_addr_i == VALUE_OFFSET)  ? value_q : 8'h00;

    // Next index: host write wins over advance
    always_comb begin
        index_d = index_q;
        if (sel_wr) begin
            index_d = reg_wdata_i[3:0];
        end else if (block_step) begin
            index_d = index_q + 4'h1;
        end
    end

    // Fetch sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FETCH_IDLE: if (fetch_start) state_d = FETCH_RUN;
            FETCH_RUN:  if (fetch_done) state_d = FETCH_IDLE;
            default:    state_d = FETCH_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= FETCH_IDLE;
            wait_q  <= FETCH_WAIT_SHORT;
            index_q <= SELECT_RESET[3:0];
            auto_q  <= SELECT_RESET[SEL_AUTO_BIT];
            short_q <= SELECT_RESET[SEL_SHORT_BIT];
        end else begin
            state_q <= state_d;
            index_q <= index_d;
            if (sel_wr) begin
                auto_q  <= reg_wdata_i[SEL_AUTO_BIT];
                short_q <= reg_wdata_i[SEL_SHORT_BIT];
            end
            // Short strobe halves the fetch time
            if (fetch_start) begin
                wait_q <= (sel_wr ? reg_wdata_i[SEL_SHORT_BIT] : short_q) ? FETCH_WAIT_SHORT : FETCH_WAIT_LONG;
            end else begin
                wait_q <= FETCH_WAIT_SHORT;
            end
        end
    end

    // value register holds written or fetched byte
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            value_q <= VALUE_RESET;
        end else if (idx_wr) begin
            value_q <= reg_wdata_i;
        end else if (fetch_done) begin
            value_q <= internal_rd;
        end
    end

    // Snapshot and match byte storage
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bytes
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    snap_q[g]  <= 8'h00;
                    match_q[g] <= 8'h00;
                end else begin
                    if (capture_cmd) begin
                        snap_q[g] <= timer_q[8*g +: 8];
                    end else if (idx_wr && (index_q == (IDX_SNAP0 + 4'(g)))) begin
                        snap_q[g] <= reg_wdata_i;
                    end
                    if (idx_wr && (index_q == (IDX_MATCH0 + 4'(g)))) begin
                        match_q[g] <= reg_wdata_i;
                    end
                end
            end
        end
    endgenerate

    // Control register; missing flag set wins over clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q     <= 1'b0;
            missdet_q <= 1'b0;
            missing_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                run_q     <= reg_wdata_i[CTRL_RUN_BIT];
                missdet_q <= reg_wdata_i[CTRL_MISSDET_BIT];
            end
            if (miss_event) begin
                missing_q <= 1'b1;
            end else if (ctrl_wr && !reg_wdata_i[CTRL_MISSING_BIT]) begin
                missing_q <= 1'b0;
            end
        end
    end

    // Oscillator configuration and load capacitance setting
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            osc_type_select_q          <= 1'b0;
            amplitude_control_enable_q <= 1'b0;
            bias_double_select_q       <= 1'b0;
            osc_power_enable_q         <= 1'b0;
            load_cap_config_q          <= LOADCAP_RESET;
        end else begin
            if (osc_wr) begin
                osc_type_select_q          <= reg_wdata_i[OSC_TYPE_BIT];
                amplitude_control_enable_q <= reg_wdata_i[OSC_AMP_BIT];
                bias_double_select_q       <= reg_wdata_i[OSC_BIAS_BIT];
                osc_power_enable_q         <= reg_wdata_i[OSC_POWER_BIT];
            end
            if (loadcap_wr) begin
                load_cap_config_q <= reg_wdata_i[3:0];
            end
        end
    end

    // Crystal valid after blanking
    // self-oscillation valid at once
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            startup_q        <= 32'h0000_0000;
            osc_valid_flag_q <= 1'b0;
        end else if (!osc_power_enable_q) begin
            startup_q        <= 32'h0000_0000;
            osc_valid_flag_q <= 1'b0;
        end else if (!osc_type_select_q) begin
            osc_valid_flag_q <= 1'b1;
        end else if (startup_q >= 32'(STARTUP_LEN - 1)) begin
            osc_valid_flag_q <= 1'b1;
        end else begin
            startup_q <= startup_q + 32'h0000_0001;
        end
    end

    // Load cap steps up from smallest in crystal mode, follows directly otherwise
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cap_step_q <= LOADCAP_RESET;
        end else if (!osc_type_select_q || (cap_step_q > load_cap_config_q)) begin
            cap_step_q <= load_cap_config_q;
        end else if (!osc_power_enable_q) begin
            cap_step_q <= LOADCAP_RESET;
        end else if (tick && osc_valid_flag_q && (cap_step_q != load_cap_config_q)) begin
            cap_step_q <= cap_step_q + 4'h1;
        end
    end

    // Timebase divider
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= 11'h000;
        end else if (!osc_power_enable_q || (div_q == 11'h000)) begin
            div_q <= div_limit - 11'h001;
        end else begin
            div_q <= div_q - 11'h001;
        end
    end

    // Missing clock counter, restarted by every tick
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            miss_cnt_q <= 12'h000;
        end else if (!missdet_q || tick || miss_event) begin
            miss_cnt_q <= 12'h000;
        end else begin
            miss_cnt_q <= miss_cnt_q + 12'h001;
        end
    end

    // Timer counts ticks while running
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timer_q <= 32'h0000_0000;
        end else if (load_cmd) begin
            timer_q <= snap_word;
        end else if (run_q && tick) begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end

    // Registered outputs
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o   <= 8'h00;
            rtc_tick_o    <= 1'b0;
            osc_missing_o <= 1'b0;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
            rtc_tick_o    <= tick;
            osc_missing_o <= missing_q;
        end
    end

endmodule // rtc_window

`default_nettype wire

// ### tb/rtc_window_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_window_chk
    import rtc_window_pkg::*;
#(parameter int STARTUP_LEN = 20) (
    // Clock, reset, bus
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    // Watched outputs
    input wire logic [7:0] reg_rdata_o,
    input wire logic       rtc_tick_o,
    input wire logic       osc_missing_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Bus cycle shapes
    sequence s_quiet; !reg_wr_i && !reg_rd_i; endsequence
    sequence s_sel_rd; reg_rd_i && reg_addr_i == SELECT_OFFSET; endsequence
    sequence s_sel_wr; reg_wr_i && reg_addr_i == SELECT_OFFSET && !reg_wdata_i[SEL_BUSY_BIT]; endsequence
    sequence s_fetch; reg_wr_i && reg_addr_i == SELECT_OFFSET && reg_wdata_i[SEL_BUSY_BIT]; endsequence
    sequence s_odd_rd; reg_rd_i && reg_addr_i != SELECT_OFFSET && reg_addr_i != VALUE_OFFSET; endsequence
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    property p_unmapped; s_odd_rd |=> reg_rdata_o == 8'h00; endproperty
    property p_bit5; s_sel_rd |=> !reg_rdata_o[5]; endproperty
    property p_back; s_quiet [*3] ##1 s_sel_wr ##1 s_sel_rd |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h5f);
    endproperty
    property p_busy_on; s_fetch ##1 s_sel_rd |=> reg_rdata_o[SEL_BUSY_BIT]; endproperty
    property p_busy_off; s_fetch ##1 s_quiet [*3] ##1 s_sel_rd |=> !reg_rdata_o[SEL_BUSY_BIT]; endproperty
    property p_tick; rtc_tick_o |=> (!rtc_tick_o) [*8]; endproperty
    property p_miss; rtc_tick_o |=> (!$rose(osc_missing_o)) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_bit5: assert property (p_bit5) else $error("unused select bit set");
    a_back: assert property (p_back) else $error("select readback wrong");
    a_busy_on: assert property (p_busy_on) else $error("busy not set");
    a_busy_off: assert property (p_busy_off) else $error("busy stuck");
    a_tick: assert property (p_tick) else $error("tick too close");
    a_miss: assert property (p_miss) else $error("missing flag despite tick");
endmodule // rtc_window_chk
bind rtc_window rtc_window_chk #(.STARTUP_LEN(STARTUP_LEN)) u_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rtc_tick_o(rtc_tick_o),
    .osc_missing_o(osc_missing_o)
);
`default_nettype wire

// ### tb/rtc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model
    import rtc_window_pkg::*;
#(parameter int STARTUP_LEN = 20) (
    // Clock
    input  wire logic      clock_i,
    // Register bus
    output var logic [7:0] reg_addr_o,
    output var logic [7:0] reg_wdata_o,
    output var logic       reg_wr_o,
    output var logic       reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    // Quiet bus at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    // Write, strobe kept up for back to back use
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clock_i);
        #1;
    endtask
    // Released bus shows no old value
    task automatic idle();
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
        @(posedge clock_i);
        #1;
    endtask
    // Read, answer taken a cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge clock_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        @(posedge clock_i);
        #1;
        d = reg_rdata_i;
    endtask
    // Indirect store
    task automatic put(input logic [3:0] i, input logic [7:0] d);
        wr(SELECT_OFFSET, {4'h0, i});
        wr(VALUE_OFFSET, d);
    endtask
    // Indirect fetch, then select and value read
    task automatic get(input logic [3:0] i, output logic [7:0] d, output logic [7:0] s);
        wr(SELECT_OFFSET, {4'h8, i});
        repeat (3) idle();
        rd(SELECT_OFFSET, s);
        rd(VALUE_OFFSET, d);
    endtask
    // Crystal bring-up
    task automatic xtal_start(input logic [3:0] cap, output logic ok);
        logic [7:0] d, s;
        int n;
        put(IDX_OSC, 8'h80);
        put(IDX_OSC, 8'hc0);
        put(IDX_LOADCAP, {4'h0, cap});
        put(IDX_OSC, 8'hc1);
        repeat (STARTUP_LEN) idle();
        d = 8'h00;
        for (n = 0; n < 50 && !d[OSC_VALID_BIT]; n++) get(IDX_OSC, d, s);
        ok = d[OSC_VALID_BIT];
        d = 8'h00;
        for (n = 0; n < 600 && !d[LOADCAP_READY_BIT]; n++) get(IDX_LOADCAP, d, s);
        ok = ok & d[LOADCAP_READY_BIT];
        put(IDX_CTRL, 8'h41);
        repeat (STARTUP_LEN) idle();
    endtask
    task automatic self_start(input logic b, input logic [3:0] cap);
        put(IDX_OSC, {2'b00, b, 5'h00});
        put(IDX_LOADCAP, {4'h0, cap});
        put(IDX_OSC, {2'b00, b, 5'h01});
    endtask
endmodule // rtc_host_model
`default_nettype wire

// ### tb/rtc_window_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_window_tb
    import rtc_window_pkg::*;
;
    localparam int START = 20;
    logic       clock_i, sys_rst_i, reg_wr, reg_rd, rtc_tick, osc_missing, ok, bias;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, s;
    logic [7:0] b [4];
    logic [3:0] cap;
    int         errors, checked, n, p;
    // Design and host
    rtc_window #(.STARTUP_LEN(START)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .rtc_tick_o(rtc_tick), .osc_missing_o(osc_missing));
    rtc_host_model #(.STARTUP_LEN(START)) host (.clock_i(clock_i), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
    // Clock
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [15:0] period_exp(input logic xt, input logic bs, input logic [3:0] c);
        if (xt) return 16'(CRYSTAL_DIV);
        return 16'(bs ? SELF_HIGH_DIV : SELF_LOW_DIV) + 16'(c) * 16'(TRIM_STEP);
    endfunction
    // Cycles from one tick to the next
    task automatic measure(output int q);
        int k;
        q = 0;
        for (k = 0; k < 3000 && rtc_tick !== 1'b1; k++) begin
            @(posedge clock_i);
            #1;
        end
        do begin
            @(posedge clock_i);
            #1;
            q++;
        end while (rtc_tick !== 1'b1 && q < 3000);
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge clock_i);
        errors++;
        wrap_up();
    end
    initial begin
        errors = 0;
        checked = 0;
        sys_rst_i = 1'b1;
        void'($urandom(1653));
        repeat (16) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        host.rd(SELECT_OFFSET, d);
        check(16'(d), 16'h0000);
        host.rd(VALUE_OFFSET, d);
        check(16'(d), 16'h0000);
        for (n = 0; n < 6; n++) begin
            d = 8'($urandom());
            if (d == SELECT_OFFSET || d == VALUE_OFFSET) d = 8'h00;
            host.wr(d, 8'hff);
            host.rd(d, s);
            check(16'(s), 16'h0000);
            d = 8'($urandom()) & 8'h7f;
            repeat (3) host.idle();
            host.wr(SELECT_OFFSET, d);
            host.rd(SELECT_OFFSET, s);
            check(16'(s), 16'(d & 8'h5f));
        end
        // Block store over match bytes
        host.wr(SELECT_OFFSET, {4'h0, IDX_MATCH0});
        for (n = 0; n < 4; n++) begin
            b[n] = 8'($urandom());
            host.wr(VALUE_OFFSET, b[n]);
        end
        host.rd(SELECT_OFFSET, d);
        check(16'(d), 16'h000c);
        // Block fetch with automatic reads
        host.wr(SELECT_OFFSET, {4'hc, IDX_MATCH0});
        host.rd(SELECT_OFFSET, d);
        check(16'(d[SEL_BUSY_BIT]), 16'h0001);
        repeat (3) host.idle();
        for (n = 0; n < 4; n++) begin
            host.rd(VALUE_OFFSET, d);
            check(16'(d), 16'(b[n]));
            repeat (3) host.idle();
        end
        host.rd(SELECT_OFFSET, d);
        check(16'(d), 16'h004c);
        // Self-oscillating rates
        for (n = 0; n < 3; n++) begin
            bias = (n != 0);
            cap = (n == 2) ? 4'($urandom()) : 4'h0;
            host.self_start(bias, cap);
            host.get(IDX_OSC, d, s);
            check(16'(s[SEL_BUSY_BIT]), 16'h0000);
            check(16'(d[OSC_VALID_BIT]), 16'h0001);
            measure(p);
            measure(p);
            check(16'(p), period_exp(1'b0, bias, cap));
        end
        host.xtal_start(4'h3, ok);
        check(16'(ok), 16'h0001);
        measure(p);
        measure(p);
        check(16'(p), period_exp(1'b1, 1'b0, 4'h0));
        check(16'(osc_missing), 16'h0000);
        // Oscillator lost
        host.put(IDX_OSC, 8'hc0);
        repeat (2100) host.idle();
        check(16'(osc_missing), 16'h0001);
        // External clock: lowest bias, amplitude control off, then clear and recheck
        host.put(IDX_OSC, 8'h81);
        host.put(IDX_CTRL, 8'h41);
        repeat (START) host.idle();
        host.get(IDX_CTRL, d, s);
        check(16'(d[CTRL_MISSING_BIT]), 16'h0000);
        check(16'(osc_missing), 16'h0000);
        wrap_up();
    end
endmodule // rtc_window_tb
`default_nettype wire
